//--- rtl/pid_pkg.sv
// constants for the pci/isa address decoder: commands, address blocks,
// config bit positions and isa cycle timing.
// assumes 64 kbyte block granularity for every fixed window.
package pid_pkg;
    // pci bus commands
    localparam logic [3:0] CMD_IO_RD   = 4'h2;
    localparam logic [3:0] CMD_IO_WR   = 4'h3;
    localparam logic [3:0] CMD_MEM_RD  = 4'h6;
    localparam logic [3:0] CMD_MEM_WR  = 4'h7;
    localparam logic [3:0] CMD_CFG_RD  = 4'hA;
    localparam logic [3:0] CMD_CFG_WR  = 4'hB;
    localparam logic [3:0] CMD_MEM_RDM = 4'hC;
    localparam logic [3:0] CMD_MEM_RDL = 4'hE;
    localparam logic [3:0] CMD_MEM_WRI = 4'hF;
    // 64 kbyte block numbers of the bios windows (addr[31:16])
    localparam logic [15:0] BLK_BIOS_UP   = 16'h000F;
    localparam logic [15:0] BLK_BIOS_LO   = 16'h000E;
    localparam logic [15:0] BLK_ALIAS_UP  = 16'hFFFF;
    localparam logic [15:0] BLK_ALIAS_LO  = 16'hFFFE;
    localparam logic [15:0] BLK_EXT_FIRST = 16'hFFF8;
    localparam logic [15:0] BLK_EXT_LAST  = 16'hFFFD;
    localparam logic [15:0] BLK_1M_FIRST  = 16'hFFF0;
    localparam logic [15:0] BLK_1M_LAST   = 16'hFFF7;
    // pci top byte for the 16 mbyte isa window
    localparam logic [7:0]  PCI_ISA_TOP   = 8'h00;
    // isa master blocks (isa_addr[26:16])
    localparam logic [10:0] IBLK_512K     = 11'h008;
    localparam logic [10:0] IBLK_640K     = 11'h00A;
    localparam logic [10:0] IBLK_LOW_BIOS = 11'h00E;
    localparam logic [10:0] IBLK_1M       = 11'h010;
    // peripheral_select_config bits
    localparam int PSC_WR_EN  = 2;
    localparam int PSC_LO_EN  = 6;
    localparam int PSC_EXT_EN = 7;
    localparam int PSC_1M_EN  = 9;
    // memory_top_limit bits
    localparam int MTL_512_BIT = 1;
    localparam int MTL_E_BIT   = 3;
    localparam int MTL_LSB     = 3;
    localparam int MTL_MSB     = 7;
    // window size code: 32 kbyte shifted by code
    localparam int WIN_MIN_SHIFT = 15;
    // forwarded cycle length in isa bus clocks, and default clk cycles per isa bus clock
    localparam int ISA_DEF_CYC = 6;
    localparam int ISA_DIV_DEF = 4;
    // one-hot cycle states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SUB  = 4'b0010,
        ST_ISA  = 4'b0100,
        ST_HOLD = 4'b1000
    } pid_state_t;
endpackage

//--- rtl/pid_dec_if.sv
// bios window decode results passed from the bios decoder to the top.
// assumes a purely combinational producer.
`timescale 1ns/100ps
`default_nettype none
interface pid_dec_if;
    logic bios_zone; // address lies in any bios window
    logic bios_hit;  // window enabled, forward to isa
    logic rom_sel;   // rom select wanted for this access
    modport dec (output bios_zone, output bios_hit, output rom_sel);
    modport sink (input bios_zone, input bios_hit, input rom_sel);
endinterface
`default_nettype wire

//--- rtl/pid_win_match.sv
// power-of-two window matcher, 32 kbyte to 4 mbyte.
// assumes base is aligned to the window size.
`timescale 1ns/100ps
`default_nettype none
module pid_win_match #(
    parameter int AW = 32
) (
    // window setup
    input  wire logic [AW-1:0] base,
    input  wire logic [2:0]    size_code,
    input  wire logic          en,
    // address under test
    input  wire logic [AW-1:0] addr,
    output logic               hit
);
    // shift reaches bit 22 for the largest window
    if (AW < 23) begin : g_bad_aw
        $error("AW too narrow");
    end

    // low bits ignored inside the window
    logic [AW-1:0] span;
    assign span = (AW'(1) << (pid_pkg::WIN_MIN_SHIFT + int'(size_code))) - AW'(1);
    assign hit  = en && ((addr & ~span) == (base & ~span));
endmodule
`default_nettype wire

//--- rtl/pid_bios_dec.sv
// bios window decoder: enables per window and the write protect bit.
// assumes the select config is stable during an address phase.
`timescale 1ns/100ps
`default_nettype none
module pid_bios_dec (
    // access
    input  wire logic [31:0] addr,
    input  wire logic        write,
    // config
    input  wire logic [15:0] sel_cfg,
    // results
    pid_dec_if.dec           dec
);
    logic [15:0] blk; // 64 kbyte block number
    logic up, lo, ext, m1, hit;
    assign blk = addr[31:16];
    assign up  = (blk == pid_pkg::BLK_BIOS_UP) || (blk == pid_pkg::BLK_ALIAS_UP);
    assign lo  = (blk == pid_pkg::BLK_BIOS_LO) || (blk == pid_pkg::BLK_ALIAS_LO);
    assign ext = (blk >= pid_pkg::BLK_EXT_FIRST) && (blk <= pid_pkg::BLK_EXT_LAST);
    assign m1  = (blk >= pid_pkg::BLK_1M_FIRST) && (blk <= pid_pkg::BLK_1M_LAST);
    // top block never gated
    assign hit = up
        || (lo && sel_cfg[pid_pkg::PSC_LO_EN])
        || (ext && sel_cfg[pid_pkg::PSC_EXT_EN])
        || (m1 && sel_cfg[pid_pkg::PSC_1M_EN]);
    assign dec.bios_zone = up || lo || ext || m1;
    assign dec.bios_hit  = hit;
    // write protect keeps the select off for writes
    assign dec.rom_sel   = hit && (!write || sel_cfg[pid_pkg::PSC_WR_EN]);
endmodule
`default_nettype wire

//--- rtl/pid_addr_decoder.sv
// pci/isa bridge address decoder: pci forward and claim decisions,
// bios rom select, default isa cycle timing and isa master routing.
// assumes all inputs are synchronous to clk; pci_end closes every
// cycle this block has taken.
`timescale 1ns/100ps
`default_nettype none
module pid_addr_decoder #(
    parameter int ISA_DIV = pid_pkg::ISA_DIV_DEF // clk cycles per isa bus clock
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // configuration
    input  wire logic [15:0] peripheral_select_config,
    input  wire logic [7:0]  memory_top_limit,
    input  wire logic        subtractive_en,
    input  wire logic        ide_decode_en,
    input  wire logic        pm12_en,
    input  wire logic [31:0] pm12_base,
    input  wire logic [2:0]  pm12_size,
    input  wire logic        pm13_en,
    input  wire logic [31:0] pm13_base,
    input  wire logic [2:0]  pm13_size,
    input  wire logic        apic_en,
    input  wire logic [31:0] apic_base,
    input  wire logic [2:0]  apic_size,
    input  wire logic        hole_en,
    input  wire logic [26:0] hole_base,
    input  wire logic [2:0]  hole_size,
    // pci target side
    input  wire logic        pci_start,
    input  wire logic [31:0] pci_addr,
    input  wire logic [3:0]  pci_cmd,
    input  wire logic        pci_int_hit,
    input  wire logic        pci_ide_hit,
    input  wire logic        pci_isa_io_hit,
    input  wire logic        pci_sub_slot,
    input  wire logic        pci_other_claim,
    input  wire logic        pci_end,
    // pci decisions
    output logic             pci_claim_pos,
    output logic             pci_claim_sub,
    output logic             pci_to_isa,
    output logic             pci_to_internal,
    output logic             pci_to_ide,
    // isa cycle
    input  wire logic        isa_slave_claim,
    input  wire logic        isa_slave_ready,
    input  wire logic [7:0]  isa_data_in,
    output logic             bios_rom_select_n,
    output logic             isa_run,
    output logic             isa_8bit,
    output logic             isa_done,
    output logic [7:0]       isa_rd_data,
    // isa master and dma side
    input  wire logic        isa_req,
    input  wire logic [26:0] isa_addr,
    input  wire logic        isa_io,
    input  wire logic        isa_legacy_hit,
    output logic             isa_to_pci,
    output logic             isa_keep,
    output logic             isa_to_internal
);
    // default cycle length in clk cycles
    localparam int ISA_CYC_CLKS = pid_pkg::ISA_DEF_CYC * ISA_DIV;
    localparam int CNT_W = 8;

    // refuse settings the counter cannot hold
    if (ISA_DIV < 1 || ISA_CYC_CLKS > 255) begin : g_bad_div
        $error("ISA_DIV out of range");
    end

    // ---------------- pci command decode ----------------
    wire is_mem_wr = (pci_cmd == pid_pkg::CMD_MEM_WR) || (pci_cmd == pid_pkg::CMD_MEM_WRI);
    wire is_mem_rd = (pci_cmd == pid_pkg::CMD_MEM_RD) || (pci_cmd == pid_pkg::CMD_MEM_RDM)
                  || (pci_cmd == pid_pkg::CMD_MEM_RDL);
    wire is_mem = is_mem_wr || is_mem_rd;
    wire is_io  = (pci_cmd == pid_pkg::CMD_IO_RD) || (pci_cmd == pid_pkg::CMD_IO_WR);
    wire is_cfg = (pci_cmd == pid_pkg::CMD_CFG_RD) || (pci_cmd == pid_pkg::CMD_CFG_WR);
    wire is_wr  = is_mem_wr || (pci_cmd == pid_pkg::CMD_IO_WR);

    // below the 16 mbyte isa ceiling
    wire below16 = (pci_addr[31:24] == pid_pkg::PCI_ISA_TOP);

    // ---------------- window matchers ----------------
    logic pm12_hit, pm13_hit, apic_hit, hole_hit;

    // power-management device 12 window
    pid_win_match #(.AW(32)) u_pm12 (
        .base      (pm12_base),
        .size_code (pm12_size),
        .en        (pm12_en),
        .addr      (pci_addr),
        .hit       (pm12_hit)
    );
    // power-management device 13 window
    pid_win_match #(.AW(32)) u_pm13 (
        .base      (pm13_base),
        .size_code (pm13_size),
        .en        (pm13_en),
        .addr      (pci_addr),
        .hit       (pm13_hit)
    );
    // io apic window
    pid_win_match #(.AW(32)) u_apic (
        .base      (apic_base),
        .size_code (apic_size),
        .en        (apic_en),
        .addr      (pci_addr),
        .hit       (apic_hit)
    );
    // memory hole seen by isa masters
    pid_win_match #(.AW(27)) u_hole (
        .base      (hole_base),
        .size_code (hole_size),
        .en        (hole_en),
        .addr      (isa_addr),
        .hit       (hole_hit)
    );

    // ---------------- bios decode ----------------
    pid_dec_if bios_if ();
    pid_bios_dec u_bios (
        .addr  (pci_addr),
        .write (is_wr),
        .sel_cfg (peripheral_select_config),
        .dec   (bios_if)
    );

    // ---------------- pci claim decisions ----------------
    // internal registers win; config cycles never reach isa
    wire want_int = (is_io || is_cfg) && pci_int_hit;
    wire want_ide = is_io && ide_decode_en && pci_ide_hit && !want_int;
    // positive isa memory: bios regardless of decode mode
    wire pos_mem = is_mem && (bios_if.bios_hit
        || apic_hit
        || (!subtractive_en && (pm12_hit || pm13_hit)));
    wire pos_io  = is_io && pci_isa_io_hit;
    wire want_pos = !want_int && !want_ide && (pos_mem || pos_io);
    // disabled bios windows are never taken subtractively
    wire sub_mem = is_mem && below16 && !bios_if.bios_zone;
    wire sub_io  = is_io && !pci_isa_io_hit;
    wire want_sub = subtractive_en && !want_int && !want_ide && !want_pos
                 && (sub_mem || sub_io);

    // ---------------- cycle state ----------------
    pid_pkg::pid_state_t state;
    pid_pkg::pid_state_t next_state;
    logic             cyc_wr;     // captured write direction
    logic             cyc_rom;    // captured rom select wish
    logic [CNT_W-1:0] cnt;        // clk cycles into isa cycle
    logic             slave_seen; // slave took the cycle

    wire st_idle = (state == pid_pkg::ST_IDLE);
    wire st_sub  = (state == pid_pkg::ST_SUB);
    wire st_isa  = (state == pid_pkg::ST_ISA);
    wire st_hold = (state == pid_pkg::ST_HOLD);
    wire take    = st_idle && pci_start;
    wire sub_win = st_sub && pci_sub_slot && !pci_other_claim;
    // default cycle runs its full 6 bus clocks
    wire def_end = !slave_seen && !isa_slave_claim
                && (cnt == CNT_W'(ISA_CYC_CLKS - 1));
    wire slv_end = (slave_seen || isa_slave_claim) && isa_slave_ready;
    wire isa_end = st_isa && (def_end || slv_end);

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            pid_pkg::ST_IDLE: begin
                if (pci_start && want_pos) begin
                    next_state = pid_pkg::ST_ISA;
                end else if (pci_start && want_sub) begin
                    next_state = pid_pkg::ST_SUB;
                end else if (pci_start && (want_int || want_ide)) begin
                    next_state = pid_pkg::ST_HOLD;
                end
            end
            pid_pkg::ST_SUB: begin
                // another agent took it, or master gave up
                if (pci_end) begin
                    next_state = pid_pkg::ST_IDLE;
                end else if (sub_win) begin
                    next_state = pid_pkg::ST_ISA;
                end else if (pci_sub_slot) begin
                    next_state = pid_pkg::ST_HOLD;
                end
            end
            pid_pkg::ST_ISA: begin
                if (isa_end) begin
                    next_state = pid_pkg::ST_HOLD;
                end
            end
            pid_pkg::ST_HOLD: begin
                if (pci_end) begin
                    next_state = pid_pkg::ST_IDLE;
                end
            end
            default: next_state = pid_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= pid_pkg::ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // claim flags, captured once at the address phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pci_claim_pos   <= 1'b0;
            pci_to_internal <= 1'b0;
            pci_to_ide      <= 1'b0;
            cyc_wr          <= 1'b0;
            cyc_rom         <= 1'b0;
        end else if (ce) begin
            if (take) begin
                pci_claim_pos   <= want_int || want_ide || want_pos;
                pci_to_internal <= want_int;
                pci_to_ide      <= want_ide;
                cyc_wr          <= is_wr;
                cyc_rom         <= is_mem && bios_if.rom_sel;
            end else if ((st_hold || st_sub) && pci_end) begin
                pci_claim_pos   <= 1'b0;
                pci_to_internal <= 1'b0;
                pci_to_ide      <= 1'b0;
                cyc_rom         <= 1'b0;
            end
        end
    end

    // forward and subtractive claim, held to cycle end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pci_to_isa    <= 1'b0;
            pci_claim_sub <= 1'b0;
        end else if (ce) begin
            if (take && want_pos) begin
                pci_to_isa <= 1'b1;
            end else if (sub_win) begin
                pci_to_isa    <= 1'b1;
                pci_claim_sub <= 1'b1;
            end else if (st_hold && pci_end) begin
                pci_to_isa    <= 1'b0;
                pci_claim_sub <= 1'b0;
            end
        end
    end

    // isa cycle: run flag, rom select, cycle counter
    wire enter_isa = (take && want_pos) || sub_win;
    wire rom_now   = take ? (is_mem && bios_if.rom_sel) : cyc_rom;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            isa_run           <= 1'b0;
            bios_rom_select_n <= 1'b1;
            cnt               <= '0;
            slave_seen        <= 1'b0;
            isa_8bit          <= 1'b0;
        end else if (ce) begin
            if (enter_isa) begin
                isa_run           <= 1'b1;
                bios_rom_select_n <= !rom_now;
                cnt               <= '0;
                slave_seen        <= 1'b0;
                isa_8bit          <= 1'b1;
            end else if (isa_end) begin
                isa_run           <= 1'b0;
                bios_rom_select_n <= 1'b1;
                isa_8bit          <= 1'b0;
            end else if (st_isa) begin
                cnt <= cnt + CNT_W'(1);
                if (isa_slave_claim) begin
                    // a claiming slave sets its own width and end
                    slave_seen <= 1'b1;
                    isa_8bit   <= 1'b0;
                end
            end
        end
    end

    // completion pulse and read data from the bus lines
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            isa_done    <= 1'b0;
            isa_rd_data <= 8'h00;
        end else if (ce) begin
            isa_done <= isa_end;
            if (isa_end && !cyc_wr) begin
                isa_rd_data <= isa_data_in;
            end
        end
    end

    // ---------------- isa master and dma routing ----------------
    wire [10:0] iblk = isa_addr[26:16];
    wire [5:0]  top6 = {1'b0, memory_top_limit[pid_pkg::MTL_MSB:pid_pkg::MTL_LSB]} + 6'h01;
    wire [10:0] tom_blk = {1'b0, top6, 4'h0}; // top of memory, 64k blocks
    wire r_low  = iblk < pid_pkg::IBLK_512K;
    wire r_512  = (iblk >= pid_pkg::IBLK_512K) && (iblk < pid_pkg::IBLK_640K)
               && !memory_top_limit[pid_pkg::MTL_512_BIT];
    wire r_e    = (iblk == pid_pkg::IBLK_LOW_BIOS)
               && !peripheral_select_config[pid_pkg::PSC_LO_EN]
               && memory_top_limit[pid_pkg::MTL_E_BIT];
    wire r_ext  = (iblk >= pid_pkg::IBLK_1M) && (iblk < tom_blk) && !hole_hit;
    // anything else, including above top, stays on isa
    wire mem_pci = !isa_io && (r_low || r_512 || r_e || r_ext);
    // i/o from isa masters only ever hits legacy registers
    wire io_int  = isa_io && isa_legacy_hit;

    // routing held while the master request stands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            isa_to_pci      <= 1'b0;
            isa_keep        <= 1'b0;
            isa_to_internal <= 1'b0;
        end else if (ce) begin
            isa_to_pci      <= isa_req && mem_pci;
            isa_keep        <= isa_req && !isa_io && !mem_pci;
            isa_to_internal <= isa_req && io_int;
        end
    end

    // ---------------- checks ----------------
    // cycles counted in a default isa cycle
    logic [CNT_W-1:0] chk_len;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_len <= '0;
        end else if (ce) begin
            chk_len <= isa_end ? '0 : (st_isa ? chk_len + CNT_W'(1) : '0);
        end
    end

    sequence s_take_upper;
        ce && take && is_mem && ((pci_addr[31:16] == pid_pkg::BLK_BIOS_UP)
            || (pci_addr[31:16] == pid_pkg::BLK_ALIAS_UP));
    endsequence
    sequence s_take_low_off;
        ce && take && is_mem && (pci_addr[31:16] == pid_pkg::BLK_BIOS_LO)
            && !peripheral_select_config[pid_pkg::PSC_LO_EN] && !subtractive_en;
    endsequence

    upper_bios_fwd_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_take_upper |=> pci_to_isa && pci_claim_pos && isa_run)
        else $error("upper bios not forwarded");
    upper_bios_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_take_upper ##0 !is_wr |=> !bios_rom_select_n)
        else $error("rom select missing on bios read");
    bios_wr_prot_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_take_upper ##0 is_wr && !peripheral_select_config[pid_pkg::PSC_WR_EN]
        |=> bios_rom_select_n)
        else $error("rom select on protected write");
    low_bios_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_take_low_off |=> !pci_to_isa && bios_rom_select_n)
        else $error("disabled lower bios forwarded");
    ext_bios_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && take && is_mem && !is_wr && (pci_addr[31:16] >= pid_pkg::BLK_EXT_FIRST)
        && (pci_addr[31:16] <= pid_pkg::BLK_EXT_LAST)
        && peripheral_select_config[pid_pkg::PSC_EXT_EN]
        |=> pci_to_isa && !bios_rom_select_n)
        else $error("extended bios not forwarded");
    isa_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && isa_req && !isa_io && (isa_addr[26:16] < pid_pkg::IBLK_512K)
        |=> isa_to_pci && !isa_keep)
        else $error("low isa memory not sent to pci");
    isa_io_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && isa_req && isa_io |=> !isa_to_pci)
        else $error("isa i/o reached pci");
    isa_above_top_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && isa_req && !isa_io && (isa_addr[26:16] >= tom_blk)
        |=> isa_keep && !isa_to_pci)
        else $error("above top not kept on isa");
    def_cycle_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && isa_end && !slave_seen && !isa_slave_claim
        |-> chk_len == CNT_W'(ISA_CYC_CLKS - 1))
        else $error("default isa cycle length wrong");
    hold_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && st_isa && !isa_end |=> $stable(pci_to_isa) && $stable(pci_claim_pos))
        else $error("decision changed mid cycle");
endmodule
`default_nettype wire

//--- tb/pid_isa_bus_model.sv
// isa side seen from the bridge: no slave answers, data lines float.
// assumes one clock; the undriven bus reads as a moving pattern.
`timescale 1ns/100ps
`default_nettype none
module pid_isa_bus_model (
    // clock
    input  wire logic  clk,
    // slave response
    output logic       isa_slave_claim,
    output logic       isa_slave_ready,
    output logic [7:0] isa_data_in
);
    // no slave decodes, so every cycle runs default length
    assign isa_slave_claim = 1'h0;
    assign isa_slave_ready = 1'h0;
    // floating lines move each cycle so a stale capture shows
    logic [7:0] pat = 8'h5A; // one driver only
    always @(posedge clk) pat <= pat + 8'h01;
    assign isa_data_in = pat;
endmodule
`default_nettype wire

//--- tb/pid_addr_decoder_tb.sv
// bench for the decoder: bios forwarding, rom select, isa timing
// and isa master routing. assumes isa_div 1: six clk a cycle.
`timescale 1ns/100ps
`default_nettype none
module pid_addr_decoder_tb;
    logic        clk = 1'h0, rst_n = 1'h0, ce = 1'h1;
    logic [15:0] peripheral_select_config = 16'h0000;
    logic [7:0]  memory_top_limit = 8'h0B; // top 2 mbyte, 512k kept
    logic        subtractive_en = 1'h0, ide_decode_en = 1'h0, apic_en = 1'h0;
    logic        pm12_en = 1'h0, pm13_en = 1'h0, hole_en = 1'h0;
    logic [31:0] pm12_base = 32'h0, pm13_base = 32'h0, apic_base = 32'h0;
    logic [26:0] hole_base = 27'h0, isa_addr = 27'h0;
    logic [2:0]  pm12_size = 3'h0, pm13_size = 3'h0, apic_size = 3'h0;
    logic [2:0]  hole_size = 3'h0;
    logic        pci_start = 1'h0, pci_int_hit = 1'h0, pci_ide_hit = 1'h0;
    logic        pci_isa_io_hit = 1'h0, pci_sub_slot = 1'h0;
    logic        pci_other_claim = 1'h0, pci_end = 1'h0;
    logic [31:0] pci_addr = 32'h0;
    logic [3:0]  pci_cmd = 4'h0;
    logic        isa_req = 1'h0, isa_io = 1'h0, isa_legacy_hit = 1'h0;
    logic        isa_slave_claim, isa_slave_ready;
    logic [7:0]  isa_data_in, isa_rd_data;
    logic        pci_claim_pos, pci_claim_sub, pci_to_isa, pci_to_internal;
    logic        pci_to_ide, bios_rom_select_n, isa_run, isa_8bit, isa_done;
    logic        isa_to_pci, isa_keep, isa_to_internal;
    int          failures = 0, checks_done = 0, cycles = 0;

    pid_addr_decoder #(.ISA_DIV(1)) DUT (.*);
    pid_isa_bus_model partner (.*);

    // 200 mhz clock
    initial forever #2.5 clk = ~clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one pci memory cycle: decision, select, length, read data
    task automatic pci_cyc(input logic [31:0] a, input logic [3:0] c,
                           input logic fwd, input logic sel_n);
        int n;
        logic [7:0] d;
        n = 0;
        d = 8'h00;
        @(negedge clk);
        pci_addr = a;
        pci_cmd = c;
        pci_start = 1'h1;
        @(negedge clk);
        pci_start = 1'h0;
        chk(pci_to_isa, fwd);
        chk(pci_claim_pos, fwd);
        chk(bios_rom_select_n, sel_n);
        chk(isa_8bit, fwd);
        for (int i = 0; i < 20 && isa_done !== 1'h1; i++) begin
            n += int'(isa_run === 1'h1);
            d = isa_data_in;
            @(negedge clk);
        end
        chk(n, fwd ? 6 : 0);
        chk(isa_done, fwd);
        if (fwd && !c[0]) chk(isa_rd_data, d);
        pci_end = 1'h1;
        @(negedge clk);
        pci_end = 1'h0;
        @(negedge clk);
        chk(pci_to_isa, 1'h0);
        chk(isa_8bit, 1'h0);
    endtask

    task automatic t_bios;
        pci_cyc(32'h000F0000, pid_pkg::CMD_MEM_RD, 1'h1, 1'h0);
        pci_cyc(32'hFFFF0000, pid_pkg::CMD_MEM_WR, 1'h1, 1'h1);
        pci_cyc(32'h000E0000, pid_pkg::CMD_MEM_RD, 1'h0, 1'h1);
        pci_cyc(32'hFFF80000, pid_pkg::CMD_MEM_RD, 1'h0, 1'h1);
        pci_cyc(32'hFFF00000, pid_pkg::CMD_MEM_RD, 1'h0, 1'h1);
        peripheral_select_config = 16'h02C4;
        pci_cyc(32'hFFFE0000, pid_pkg::CMD_MEM_WR, 1'h1, 1'h0);
        pci_cyc(32'hFFFDFFFC, pid_pkg::CMD_MEM_RD, 1'h1, 1'h0);
        pci_cyc(32'hFFF7FFFC, pid_pkg::CMD_MEM_RD, 1'h1, 1'h0);
        $display("test bios done");
    endtask

    // isa master access; answer one cycle after the request
    task automatic isa_chk(input logic [26:0] a, input logic io,
                           input logic exp);
        @(negedge clk);
        isa_addr = a;
        isa_io = io;
        isa_legacy_hit = io;
        isa_req = 1'h1;
        @(negedge clk);
        chk(isa_to_pci, exp);
        chk(isa_keep, !io && !exp);
        chk(isa_to_internal, io);
        isa_req = 1'h0;
    endtask

    task automatic t_isa;
        peripheral_select_config = 16'h0000;
        isa_chk(27'h0000000, 1'h0, 1'h1);
        isa_chk(27'h0080000, 1'h0, 1'h0);
        isa_chk(27'h00A0000, 1'h0, 1'h0);
        isa_chk(27'h00E0000, 1'h0, 1'h1);
        isa_chk(27'h01FFFFF, 1'h0, 1'h1);
        isa_chk(27'h0200000, 1'h0, 1'h0);
        isa_chk(27'h0000000, 1'h1, 1'h0);
        memory_top_limit = 8'h09;
        isa_chk(27'h0080000, 1'h0, 1'h1);
        hole_en = 1'h1;
        hole_base = 27'h0100000;
        hole_size = 3'h5;
        isa_chk(27'h0100000, 1'h0, 1'h0);
        $display("test isa done");
    endtask

    // internal or ide register target
    task automatic pci_tgt(input logic [3:0] c, input logic ih, input logic dh,
                           input logic e_int, input logic e_ide);
        @(negedge clk);
        pci_cmd = c;
        pci_int_hit = ih;
        pci_ide_hit = dh;
        pci_start = 1'h1;
        @(negedge clk);
        pci_start = 1'h0;
        chk(pci_to_internal, e_int);
        chk(pci_to_ide, e_ide);
        chk(pci_claim_pos, e_int || e_ide);
        pci_end = 1'h1;
        @(negedge clk);
        pci_end = 1'h0;
        chk(pci_claim_pos, 1'h0);
    endtask

    // subtractive candidate: slot point, then default cycle
    task automatic pci_sub(input logic [31:0] a, input logic other);
        @(negedge clk);
        pci_addr = a;
        pci_cmd = pid_pkg::CMD_MEM_RD;
        pci_start = 1'h1;
        @(negedge clk);
        pci_start = 1'h0;
        pci_sub_slot = 1'h1;
        pci_other_claim = other;
        @(negedge clk);
        pci_sub_slot = 1'h0;
        pci_other_claim = 1'h0;
        chk(pci_claim_sub, !other);
        chk(pci_to_isa, !other);
        for (int i = 0; i < 20 && isa_done !== 1'h1; i++) begin
            @(negedge clk);
        end
        chk(isa_done, !other);
        pci_end = 1'h1;
        @(negedge clk);
        pci_end = 1'h0;
        chk(pci_claim_sub, 1'h0);
    endtask

    task automatic t_pci;
        pm12_en = 1'h1;
        pm12_base = 32'h0C000000;
        pm12_size = 3'h7;
        apic_en = 1'h1;
        apic_base = 32'hFEC00000;
        pci_cyc(32'h0C3FFFF0, pid_pkg::CMD_MEM_WR, 1'h1, 1'h1);
        pci_cyc(32'h0C400000, pid_pkg::CMD_MEM_RD, 1'h0, 1'h1);
        pci_cyc(32'hFEC00010, pid_pkg::CMD_MEM_RD, 1'h1, 1'h1);
        pci_tgt(pid_pkg::CMD_CFG_RD, 1'h1, 1'h0, 1'h1, 1'h0);
        ide_decode_en = 1'h1;
        pci_tgt(pid_pkg::CMD_IO_RD, 1'h0, 1'h1, 1'h0, 1'h1);
        ide_decode_en = 1'h0;
        pci_tgt(pid_pkg::CMD_IO_RD, 1'h0, 1'h1, 1'h0, 1'h0);
        subtractive_en = 1'h1;
        pci_cyc(32'h000F0000, pid_pkg::CMD_MEM_RD, 1'h1, 1'h0);
        pci_sub(32'h000C0000, 1'h0);
        pci_sub(32'h000C0000, 1'h1);
        $display("test pci done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'h1;
        t_bios;
        t_isa;
        t_pci;
        report_and_stop;
    end
endmodule
`default_nettype wire
